// File: src/bdpwm_pkg.sv
// constants shared by the battery converter pwm controller files
// assumes a 100 mhz system clock and an axi4-lite register bus
package bdpwm_pkg;
    // register indexes; byte address is four times the index
    localparam logic [7:0] IDX_POWERDOWN   = 8'h0e;
    localparam logic [7:0] IDX_HIGH_BATT   = 8'h4a;
    localparam logic [7:0] IDX_LOW_BATT    = 8'h4b;
    localparam logic [7:0] IDX_PERIOD      = 8'h5c;
    localparam logic [7:0] IDX_SW_DELAY    = 8'h5d;
    localparam logic [7:0] IDX_PULSE_WIDTH = 8'h5e;
    localparam logic [7:0] IDX_TARGET_CFG  = 8'h60;
    localparam logic [7:0] IDX_LOOP        = 8'h61;
    localparam logic [7:0] IDX_TARGET      = 8'h62;
    localparam int         ADDR_W          = 10;
    localparam int         IDX_LSB         = 2;
    // field positions
    localparam int PD_CONV_OFF_BIT = 4;
    localparam int DLY_POL_BIT     = 5;
    localparam int DLY_CAL_BIT     = 7;
    localparam int TOF_W           = 5;
    localparam int VOC_LSB         = 0;
    localparam int VCM_LSB         = 6;
    localparam int VOV_LSB         = 12;
    localparam int TRACK_BIT       = 16;
    localparam int ILIM_LSB        = 0;
    localparam int RLOOP_LSB       = 6;
    localparam int CC_BIT          = 8;
    localparam int IR_SHIFT        = 4;
    // reset values
    localparam logic [7:0]  PD_RESET     = 8'h10;
    localparam logic [7:0]  PERIOD_RESET = 8'h80;
    localparam logic [7:0]  BYTE_RESET   = 8'h00;
    localparam logic [31:0] WORD_RESET   = 32'h0000_0000;
    // timing: converter tick 61.035 ns, off time gets 4 extra ticks
    localparam logic [5:0] TOF_EXTRA   = 6'h04;
    localparam int         CLK_KHZ     = 100000;
    localparam int         CONV_KHZ    = 16384;
    localparam int         CAL_TIME_US = 100;
    localparam int         CAL_CYCLES  = CAL_TIME_US * CLK_KHZ / 1000;
    // axi answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // switch state, one-hot
    typedef enum logic [2:0] {
        BD_OFF  = 3'h1,
        BD_ON   = 3'h2,
        BD_REST = 3'h4
    } bdpwm_state_t;
endpackage : bdpwm_pkg

// File: src/bdpwm_tick_if.sv
// converter tick strobe between the tick divider and the controller
// assumes both ends sit on the same system clock
`timescale 1ns/1ps
interface bdpwm_tick_if;
    logic tick;
    modport src (output tick);
    modport snk (input tick);
endinterface : bdpwm_tick_if

// File: src/bdpwm_tick.sv
// fractional divider making the 16.384 mhz converter tick enable
// assumes clk at 100 mhz; ticks jitter by one clk, average rate exact
`timescale 1ns/1ps
module bdpwm_tick
    import bdpwm_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst_b,
    input  wire logic  ce,
    bdpwm_tick_if.src  tick_if
);
    logic [16:0] acc_reg;
    logic [16:0] acc_next;
    logic        tick_next;

    // phase accumulator, wraps at the system rate
    always_comb begin
        tick_next = 1'b0;
        acc_next  = acc_reg + 17'(CONV_KHZ);
        if (acc_next >= 17'(CLK_KHZ)) begin
            acc_next  = acc_next - 17'(CLK_KHZ);
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            acc_reg      <= 17'h0;
            tick_if.tick <= 1'b0;
        end else if (ce) begin
            acc_reg      <= acc_next;
            tick_if.tick <= tick_next;
        end
    end
endmodule : bdpwm_tick

// File: src/bdpwm_ctrl.sv
// pwm controller for an external buck-boost battery converter
// assumes axi4-lite master on clk, sense and monitor inputs synchronous
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Operation
// - the converter switches only while the power-off bit 4 is 0.
// - the pwm period is the 8-bit period setting in 61.035 ns ticks.
// - the primary switch drive asserts for a computed pulse width readable from a read-only register.
// - every period keeps the switch off for the 5-bit off setting plus 4 ticks.
// - an overload on the monitor inputs blanks the switch for the rest of the period.
// - inductor variant drives the feed-forward output inverted, transformer variant equal.
// - bit 5 of the switching delay register reads the polarity variant.
// - the sensed output is compared with the target to raise or lower switching.
// - in constant voltage the target is common-mode plus open-circuit plus overhead.
// - in constant current the target is current limit times loop resistance over 16 plus the rest.
// - with tracking off the constant current target stops at the low battery level.
module bdpwm_ctrl
    import bdpwm_pkg::*;
#(
    parameter bit SAME_POLARITY = 1'b0,
    parameter int CAL_COUNT     = CAL_CYCLES
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              ce,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [7:0]        battery_sense_input,
    input  wire logic              converter_monitor_high,
    input  wire logic              converter_monitor_low,
    output logic                   primary_switch_drive,
    output logic                   feedforward_switch_drive
);
    localparam logic FF_IDLE = !SAME_POLARITY;

    // byte-lane merge of a write into a stored word
    function automatic logic [31:0] bd_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return res;
    endfunction : bd_merge

    // battery magnitude target {cc, level} in 1.5 v steps
    function automatic logic [8:0] bd_target(input logic [31:0] cfg,
                                             input logic [31:0] loop_v,
                                             input logic [7:0]  low_lvl);
        logic [7:0]  voc;
        logic [7:0]  vcm;
        logic [7:0]  overhead_voltage;
        logic [13:0] ir;
        logic [9:0]  irs;
        logic [7:0]  lvl;
        voc = {2'h0, cfg[VOC_LSB +: 6]};
        vcm = {2'h0, cfg[VCM_LSB +: 6]};
        overhead_voltage = {4'h0, cfg[VOV_LSB +: 4]};
        ir  = 14'(loop_v[ILIM_LSB +: 6] * loop_v[RLOOP_LSB +: 8]);
        irs = 10'(ir >> IR_SHIFT); // kept wide: a wrapped product would fake current limit
        if (irs >= {2'h0, voc}) begin
            return {1'b0, vcm + voc + overhead_voltage};
        end
        lvl = irs[7:0] + vcm + overhead_voltage;
        if (!cfg[TRACK_BIT] && lvl < low_lvl) begin
            lvl = low_lvl;
        end
        return {1'b1, lvl};
    endfunction : bd_target

    bdpwm_tick_if tick_if ();

    bdpwm_tick u_tick (
        .clk     (clk),
        .rst_b   (rst_b),
        .ce      (ce),
        .tick_if (tick_if)
    );

    // register file and bus state
    logic [7:0]        pd_reg, pd_next;
    logic [7:0]        hb_reg, hb_next;
    logic [7:0]        lb_reg, lb_next;
    logic [7:0]        period_reg, period_next;
    logic [TOF_W-1:0]  tof_reg, tof_next;
    logic [31:0]       cfg_reg, cfg_next;
    logic [31:0]       loop_reg, loop_next;
    logic [31:0]       cal_cnt_reg, cal_cnt_next;
    logic              aw_full_reg, aw_full_next;
    logic              w_full_reg, w_full_next;
    logic [7:0]        widx_reg, widx_next;
    logic [31:0]       wdat_reg, wdat_next;
    logic [3:0]        wstb_reg, wstb_next;
    logic              awready_next, wready_next, bvalid_next;
    logic              arready_next, rvalid_next;
    logic [1:0]        bresp_next, rresp_next;
    logic [31:0]       rdata_next;
    logic [31:0]       wr_word;
    logic [31:0]       rd_val;
    logic              rd_hit;
    logic              wr_hit;
    logic [7:0]        ridx;
    logic [8:0]        target;
    logic              cal_busy;
    // pwm state
    bdpwm_state_t      state_reg, state_next;
    logic [7:0]        cnt_reg, cnt_next;
    logic [7:0]        pw_reg, pw_next;
    logic              blank_reg, blank_next;
    logic              ff_next;
    logic              running;
    logic              overload;
    logic              period_end;
    logic [5:0]        min_off;
    logic [7:0]        room;
    logic [7:0]        pw_lim;
    assign target   = bd_target(cfg_reg, loop_reg, lb_reg);
    assign cal_busy = (cal_cnt_reg != 32'h0);
    assign ridx     = s_axi_araddr[IDX_LSB +: 8];
    // read decode; target config and loop words read back whole, reserved bits of the other registers read as zero
    always_comb begin
        rd_val = 32'h0;
        rd_hit = 1'b1;
        unique case (ridx)
            IDX_POWERDOWN:   rd_val[7:0] = pd_reg;
            IDX_HIGH_BATT:   rd_val[7:0] = hb_reg;
            IDX_LOW_BATT:    rd_val[7:0] = lb_reg;
            IDX_PERIOD:      rd_val[7:0] = period_reg;
            IDX_SW_DELAY: begin
                rd_val[TOF_W-1:0]  = tof_reg;
                rd_val[DLY_POL_BIT] = SAME_POLARITY;
                rd_val[DLY_CAL_BIT] = cal_busy;
            end
            IDX_PULSE_WIDTH: rd_val[7:0] = pw_reg;
            IDX_TARGET_CFG:  rd_val = cfg_reg;
            IDX_LOOP:        rd_val = loop_reg;
            IDX_TARGET:      rd_val[CC_BIT:0] = target;
            default:         rd_hit = 1'b0;
        endcase
    end
    // axi write and read channels; address and data taken in any order
    always_comb begin
        pd_next      = pd_reg;
        hb_next      = hb_reg;
        lb_next      = lb_reg;
        period_next  = period_reg;
        tof_next     = tof_reg;
        cfg_next     = cfg_reg;
        loop_next    = loop_reg;
        cal_cnt_next = cal_busy ? cal_cnt_reg - 32'h1 : cal_cnt_reg;
        aw_full_next = aw_full_reg;
        w_full_next  = w_full_reg;
        widx_next    = widx_reg;
        wdat_next    = wdat_reg;
        wstb_next    = wstb_reg;
        bvalid_next  = s_axi_bvalid && !s_axi_bready;
        bresp_next   = s_axi_bresp;
        rvalid_next  = s_axi_rvalid && !s_axi_rready;
        rresp_next   = s_axi_rresp;
        rdata_next   = s_axi_rdata;
        wr_hit       = 1'b1;
        wr_word      = 32'h0;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_full_next = 1'b1;
            widx_next    = s_axi_awaddr[IDX_LSB +: 8];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_full_next = 1'b1;
            wdat_next   = s_axi_wdata;
            wstb_next   = s_axi_wstrb;
        end
        // commit one cycle after both halves are held
        if (aw_full_reg && w_full_reg && !s_axi_bvalid) begin
            aw_full_next = 1'b0;
            w_full_next  = 1'b0;
            bvalid_next  = 1'b1;
            wr_word = bd_merge(32'h0, wdat_reg, wstb_reg); // lane 0 holds the byte registers
            unique case (widx_reg)
                IDX_POWERDOWN:  pd_next     = wstb_reg[0] ? wr_word[7:0] : pd_reg;
                IDX_HIGH_BATT:  hb_next     = wstb_reg[0] ? wr_word[7:0] : hb_reg;
                IDX_LOW_BATT:   lb_next     = wstb_reg[0] ? wr_word[7:0] : lb_reg;
                IDX_PERIOD:     period_next = wstb_reg[0] ? wr_word[7:0] : period_reg;
                IDX_SW_DELAY: begin
                    tof_next = wstb_reg[0] ? wr_word[TOF_W-1:0] : tof_reg;
                    if (wr_word[DLY_CAL_BIT]) begin
                        cal_cnt_next = 32'(CAL_COUNT);
                    end
                end
                IDX_TARGET_CFG: cfg_next  = bd_merge(cfg_reg, wdat_reg, wstb_reg);
                IDX_LOOP:       loop_next = bd_merge(loop_reg, wdat_reg, wstb_reg);
                IDX_PULSE_WIDTH,
                IDX_TARGET: ; // read-only, write ignored
                default:        wr_hit = 1'b0;
            endcase
            bresp_next = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rdata_next  = rd_val;
            rresp_next  = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        awready_next = !aw_full_next && !bvalid_next;
        wready_next  = !w_full_next && !bvalid_next;
        arready_next = !rvalid_next;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pd_reg        <= PD_RESET;
            hb_reg        <= BYTE_RESET;
            lb_reg        <= BYTE_RESET;
            period_reg    <= PERIOD_RESET;
            tof_reg       <= '0;
            cfg_reg       <= WORD_RESET;
            loop_reg      <= WORD_RESET;
            cal_cnt_reg   <= WORD_RESET;
            aw_full_reg   <= 1'b0;
            w_full_reg    <= 1'b0;
            widx_reg      <= BYTE_RESET;
            wdat_reg      <= WORD_RESET;
            wstb_reg      <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= RESP_OKAY;
            s_axi_rdata   <= WORD_RESET;
        end else if (ce) begin
            pd_reg        <= pd_next;
            hb_reg        <= hb_next;
            lb_reg        <= lb_next;
            period_reg    <= period_next;
            tof_reg       <= tof_next;
            cfg_reg       <= cfg_next;
            loop_reg      <= loop_next;
            cal_cnt_reg   <= cal_cnt_next;
            aw_full_reg   <= aw_full_next;
            w_full_reg    <= w_full_next;
            widx_reg      <= widx_next;
            wdat_reg      <= wdat_next;
            wstb_reg      <= wstb_next;
            s_axi_awready <= awready_next;
            s_axi_wready  <= wready_next;
            s_axi_bvalid  <= bvalid_next;
            s_axi_bresp   <= bresp_next;
            s_axi_arready <= arready_next;
            s_axi_rvalid  <= rvalid_next;
            s_axi_rresp   <= rresp_next;
            s_axi_rdata   <= rdata_next;
        end
    end
    // off-time budget: period minus the forced minimum off window
    assign running  = !pd_reg[PD_CONV_OFF_BIT];
    assign overload = converter_monitor_high || converter_monitor_low;
    assign min_off  = {1'b0, tof_reg} + TOF_EXTRA;
    assign room     = (period_reg > {2'h0, min_off}) ? period_reg - {2'h0, min_off} : 8'h0;
    assign pw_lim   = (pw_reg < room) ? pw_reg : room;
    // period counter, blanking and regulation; counter and regulation step on the tick, overload blanks on any clk
    always_comb begin
        period_end = running && tick_if.tick && (period_reg != 8'h0)
                     && (cnt_reg >= period_reg - 8'h1);
        cnt_next   = cnt_reg;
        pw_next    = pw_reg;
        blank_next = blank_reg || overload;
        if (!running || period_reg == 8'h0) begin
            cnt_next = 8'h0;
        end else if (tick_if.tick) begin
            cnt_next = period_end ? 8'h0 : cnt_reg + 8'h1;
        end
        if (period_end) begin
            // a fresh period starts clean unless the overload persists
            blank_next = overload;
            if (battery_sense_input < target[7:0]) begin
                pw_next = (pw_reg < room) ? pw_reg + 8'h1 : pw_reg;
            end else begin
                pw_next = (pw_reg != 8'h0) ? pw_reg - 8'h1 : pw_reg;
            end
        end
        if (!running) begin
            blank_next = 1'b0;
            pw_next    = 8'h0;
        end
    end
    // switch state; width limited against the off window
    always_comb begin
        if (!running) begin
            state_next = BD_OFF;
        end else if (cnt_next < pw_lim && !blank_next) begin
            state_next = BD_ON;
        end else begin
            state_next = BD_REST;
        end
        ff_next = SAME_POLARITY ? (state_next == BD_ON)
                                : (state_next != BD_ON);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg                <= BD_OFF;
            cnt_reg                  <= 8'h0;
            pw_reg                   <= 8'h0;
            blank_reg                <= 1'b0;
            primary_switch_drive     <= 1'b0;
            feedforward_switch_drive <= FF_IDLE;
        end else if (ce) begin
            state_reg                <= state_next;
            cnt_reg                  <= cnt_next;
            pw_reg                   <= pw_next;
            blank_reg                <= blank_next;
            primary_switch_drive     <= (state_next == BD_ON);
            feedforward_switch_drive <= ff_next;
        end
    end

    // checks on the controller's own outputs and internal state
    default clocking bd_cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_overload; ce && running && overload; endsequence
    sequence s_pw_read;
        ce && s_axi_arvalid && s_axi_arready && ridx == IDX_PULSE_WIDTH;
    endsequence
    AST_OFF_IDLE: assert property ((ce && !running) |=> (state_reg == BD_OFF
        && !primary_switch_drive && feedforward_switch_drive == FF_IDLE))
        else $error("drive active while converter powered off");
    AST_PERIOD_RANGE: assert property (running && $stable(period_reg)
        && period_reg != 8'h0 |-> cnt_reg < period_reg) else $error("counter past period");
    AST_PW_READ: assert property (s_pw_read |=> s_axi_rvalid
        && s_axi_rdata == {24'h0, $past(pw_reg)}) else $error("pulse width readback wrong");
    AST_MIN_OFF: assert property ((primary_switch_drive && $stable(period_reg)
        && $stable(tof_reg)) |-> ({1'b0, cnt_reg} + {3'h0, min_off} < {1'b0, period_reg}))
        else $error("switch on inside minimum off window");
    AST_OVERLOAD: assert property (s_overload |=> !primary_switch_drive)
        else $error("switch on during overload");
    AST_POLARITY: assert property (feedforward_switch_drive
        != (primary_switch_drive ^ SAME_POLARITY)) else $error("feed-forward polarity wrong");
    AST_POL_FLAG: assert property ((ce && s_axi_arvalid && s_axi_arready
        && ridx == IDX_SW_DELAY) |=> s_axi_rdata[DLY_POL_BIT] == SAME_POLARITY)
        else $error("polarity flag wrong");
    AST_REG_UP: assert property ((ce && running && period_end
        && battery_sense_input < target[7:0] && pw_reg < room)
        |=> pw_reg == $past(pw_reg) + 8'h1)
        else $error("pulse width did not grow below target");
    AST_TARGET_CV: assert property (!target[CC_BIT] |-> target[7:0] ==
        8'(cfg_reg[VOC_LSB +: 6]) + 8'(cfg_reg[VCM_LSB +: 6]) + 8'(cfg_reg[VOV_LSB +: 4]))
        else $error("constant voltage target wrong");
    AST_TRACK_FLOOR: assert property ((target[CC_BIT] && !cfg_reg[TRACK_BIT])
        |-> target[7:0] >= lb_reg) else $error("target below low battery");
endmodule : bdpwm_ctrl

// File: tb/bdpwm_stage.sv
// model of the external switch stage and output capacitor
// assumes drives registered on clk; overload only on bench command
`timescale 1ns/1ps
module bdpwm_stage (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       drv,
    input  wire logic [1:0] ovl,
    output logic [7:0]      sense,
    output logic            mon_h,
    output logic            mon_l
);
    logic drv_d;
    // each finished pulse lifts the battery magnitude one step, no decay
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sense <= 8'h00;
            drv_d <= 1'b0;
        end else begin
            drv_d <= drv;
            if (drv_d && !drv && sense != 8'hff) sense <= sense + 8'h01;
        end
    end
    assign mon_h = ovl[0]; // monitors are plain levels here
    assign mon_l = ovl[1];
endmodule : bdpwm_stage

// File: tb/tb_bdpwm_ctrl.sv
// self-checking bench for the battery converter pwm controller
// assumes package, tick interface, design and stage model compile first
`timescale 1ns/1ps
module tb_bdpwm_ctrl;
    import bdpwm_pkg::*;
    logic              clk = 1'b0, rst_b = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, ce = 1'b1;
    logic              arv = 1'b0, rr = 1'b0, awr, wrdy, bv, arr, rvl, drv, ff, mh, ml;
    logic [ADDR_W-1:0] awa = '0, ara = '0;
    logic [31:0]       wd = '0, rdat, rv, seed = 32'hf70d;
    logic [7:0]        sense;
    logic [1:0]        brsp, rrsp, rsp, hold, ovl = 2'h0;
    int                n_errors = 0, n_checks = 0, cyc = 0, low_run = 0;
    int                tv [3][7] = '{'{20, 6, 4, 1, 32, 255, 0}, '{20, 6, 4, 1, 8, 16, 0},
                                     '{20, 6, 4, 0, 8, 16, 25}};
    bdpwm_ctrl #(.SAME_POLARITY(1'b0), .CAL_COUNT(20)) bdpwm_ctrl_i (
        .clk(clk), .rst_b(rst_b), .ce(ce), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wrdy), .s_axi_bresp(brsp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
        .s_axi_rresp(rrsp), .s_axi_rvalid(rvl), .s_axi_rready(rr),
        .battery_sense_input(sense), .converter_monitor_high(mh),
        .converter_monitor_low(ml), .primary_switch_drive(drv), .feedforward_switch_drive(ff));
    bdpwm_stage bdpwm_stage_i (.clk(clk), .rst_b(rst_b), .drv(drv), .ovl(ovl),
        .sense(sense), .mon_h(mh), .mon_l(ml));
    always #5 clk = ~clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    // opening edge keeps a new request off the edge that ended the last one
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        @(posedge clk);
        awa <= {idx, 2'b00};
        wd  <= d;
        awv <= 1'b1;
        wv  <= 1'b1;
        br  <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
        end while (!bv);
        br <= 1'b0;
        rsp = brsp; // response stands with bvalid at this edge
    endtask : wr
    task automatic rd(input logic [7:0] idx);
        @(posedge clk);
        ara <= {idx, 2'b00};
        arv <= 1'b1;
        rr  <= 1'b1;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (!rvl);
        rr  <= 1'b0;
        rv  = rdat;
        rsp = rrsp;
    endtask : rd
    task automatic rc(input logic [7:0] idx, input logic [31:0] m, input logic [31:0] e);
        rd(idx);
        chk(rv & m, e, "read data");
        chk({30'h0, rsp}, {30'h0, RESP_OKAY}, "read resp");
    endtask : rc
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // integer model of the regulation target
    function automatic logic [31:0] tgt(input int voc, vcm, overhead_voltage, trk, il, rl, lo);
        int cc = (il * rl) >> 4;
        int t = (cc < voc) ? cc + vcm + overhead_voltage : voc + vcm + overhead_voltage;
        if (cc < voc && trk == 0 && t < lo) t = lo;
        return {23'h0, cc < voc, t[7:0]};
    endfunction : tgt
    // hang guard, sized well above the whole sequence
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            stop_test;
        end
    end
    // inductor variant: drives always complementary
    always @(negedge clk) begin
        if (rst_b) chk({31'h0, ff}, {31'h0, !drv}, "feedforward");
    end
    // off run before each switch-on, six clk at least per converter tick
    always @(posedge clk) begin
        if (drv && low_run > 0) chk(32'(low_run >= 7 * 6), 32'h1, "off time");
        low_run = drv ? 0 : low_run + 1;
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        rc(IDX_POWERDOWN, 32'h10, 32'h10);
        rc(IDX_PERIOD, 32'hff, {24'h0, PERIOD_RESET});
        rc(IDX_SW_DELAY, 32'h20, 32'h0);
        chk({31'h0, drv}, 32'h0, "drive at rest");
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            wr(i % 2 ? IDX_LOW_BATT : IDX_PERIOD, seed);
            rc(i % 2 ? IDX_LOW_BATT : IDX_PERIOD, 32'hff, seed & 32'hff);
        end
        wr(IDX_PULSE_WIDTH, 32'hff);
        chk({30'h0, rsp}, {30'h0, RESP_OKAY}, "write resp");
        rc(IDX_PULSE_WIDTH, 32'hff, 32'h0);
        rd(8'h20);
        chk({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unmapped resp");
        wr(8'h20, 32'h0);
        chk({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unmapped write");
        $display("test registers done");
        for (int k = 0; k < 3; k++) begin
            wr(IDX_LOW_BATT, 32'(tv[k][6]));
            wr(IDX_TARGET_CFG, 32'(tv[k][3] << 16 | tv[k][2] << 12 | tv[k][1] << 6 | tv[k][0]));
            wr(IDX_LOOP, 32'(tv[k][5] << 6 | tv[k][4]));
            rc(IDX_TARGET, 32'h1ff, tgt(tv[k][0], tv[k][1], tv[k][2], tv[k][3], tv[k][4],
               tv[k][5], tv[k][6]));
        end
        $display("test target done");
        wr(IDX_TARGET_CFG, 32'h0001_ffff);
        wr(IDX_LOOP, 32'h0);
        wr(IDX_PERIOD, 32'h10);
        wr(IDX_POWERDOWN, 32'h0);
        wr(IDX_SW_DELAY, 32'h83);
        rc(IDX_SW_DELAY, 32'hbf, 32'h83);
        repeat (2000) @(posedge clk);
        rc(IDX_SW_DELAY, 32'hbf, 32'h03);
        rd(IDX_PULSE_WIDTH);
        chk(32'(rv > 0 && rv <= 16 - 7), 32'h1, "pulse width");
        chk(32'(sense > 0), 32'h1, "pulses seen");
        // enable low for over a period: any state that moves shows on the drives
        ce <= 1'b0;
        @(posedge clk);
        hold = {drv, ff};
        repeat (120) @(posedge clk) chk({30'h0, drv, ff}, {30'h0, hold}, "frozen drives");
        ce <= 1'b1;
        $display("test switching done");
        for (int m = 1; m < 3; m++) begin
            ovl <= m[1:0];
            repeat (2) @(posedge clk);
            repeat (40) @(negedge clk) chk({31'h0, drv}, 32'h0, "blanked");
            ovl <= 2'h0;
            repeat (300) @(posedge clk);
        end
        $display("test overload done");
        wr(IDX_POWERDOWN, 32'h10);
        repeat (3) @(posedge clk);
        chk({31'h0, drv}, 32'h0, "drive off");
        rc(IDX_PULSE_WIDTH, 32'hff, 32'h0);
        $display("test power off done");
        stop_test;
    end
endmodule : tb_bdpwm_ctrl
